/* core/cmp_irq_pkg.sv */
// constants for the comparator output conditioning and interrupt block
package cmp_irq_pkg;

  // fixed block dimensions
  localparam int NUM_CMP = 2;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // register offsets, byte addresses
  localparam logic [ADDR_W-1:0] OFF_CTRL0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL1   = 8'h04;
  localparam logic [ADDR_W-1:0] CMP_STRIDE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAG    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INTCTL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_OUTSTAT = 8'h1c;

  // comparator_control_0 field positions
  localparam int CTRL0_SYNC_BIT = 0;
  localparam int CTRL0_HYS_BIT  = 1;
  localparam int CTRL0_SP_BIT   = 2;
  localparam int CTRL0_POL_BIT  = 4;
  localparam int CTRL0_ON_BIT   = 7;

  // comparator_control_1 field positions
  localparam int CTRL1_FALL_BIT = 0;
  localparam int CTRL1_RISE_BIT = 1;

  // interrupt control field positions
  localparam int INTCTL_PERIPHERAL_IRQ_ENABLE_BIT = 0;
  localparam int INTCTL_GIE_BIT  = 1;

  // values after reset
  localparam logic [NUM_CMP-1:0] CMP_BITS_RST = 2'h0;
  localparam logic               INTCTL_RST   = 1'h0;
  localparam logic               READY_RST    = 1'h1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmp_irq_pkg

/* core/cmp_channel.sv */
// one comparator channel: synchroniser, polarity, timer latch, edge flag
`timescale 1ns/1ps
`default_nettype none

module cmp_channel (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic raw,
  input  wire logic on,
  input  wire logic polarity,
  input  wire logic sync_en,
  input  wire logic latch_fall,
  input  wire logic rise_en,
  input  wire logic fall_en,
  input  wire logic flag_clear,
  output logic      gate,
  output logic      flag
);
  import cmp_irq_pkg::*;

  logic raw_s1;
  logic raw_s2;
  logic prev_gate;
  logic value;
  logic rise_seen;
  logic fall_seen;
  logic set_now;
  logic next_gate;
  logic next_flag;

  // output conditioning and edge flag, next values
  always_comb
  begin
    value     = (on & raw_s2) ^ polarity;
    next_gate = gate;
    if (!sync_en)
    begin
      next_gate = value;
    end
    else if (latch_fall)
    begin
      next_gate = value;
    end
    rise_seen = gate & ~prev_gate;
    fall_seen = ~gate & prev_gate;
    set_now   = (rise_seen & rise_en) | (fall_seen & fall_en);
    next_flag = (flag & ~flag_clear) | set_now;
  end

  // state registers, frozen while ce is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_s1    <= 1'h0;
      raw_s2    <= 1'h0;
      gate      <= 1'h0;
      prev_gate <= 1'h0;
      flag      <= 1'h0;
    end
    else if (ce)
    begin
      raw_s1    <= raw;
      raw_s2    <= raw_s1;
      gate      <= next_gate;
      prev_gate <= gate;
      flag      <= next_flag;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rise_seen;
    ce && rise_en && gate && !prev_gate;
  endsequence

  sequence s_fall_seen;
    ce && fall_en && !gate && prev_gate;
  endsequence

  a_flag_on_edge: assert property ((s_rise_seen or s_fall_seen) |=> flag)
    else $error("enabled edge did not set the flag");

  a_set_beats_clear: assert property
    (ce && flag_clear && set_now |=> flag)
    else $error("clear won over a simultaneous edge");

  a_latch_hold: assert property
    (ce && sync_en && !latch_fall |=> $stable(gate))
    else $error("latched output moved without a falling edge");

  a_latch_take: assert property
    (ce && sync_en && latch_fall |=> gate == $past(value))
    else $error("latch missed the value at the falling edge");

  a_gate_direct: assert property
    (ce && !sync_en && on |=> gate == ($past(raw_s2) ^ $past(polarity)))
    else $error("unsynchronised output not passed through");

  a_off_polarity: assert property
    (ce && !sync_en && !on |=> gate == $past(polarity))
    else $error("disabled comparator output not set by polarity");

endmodule : cmp_channel

`default_nettype wire

/* core/comparator_output_sync_irq.sv */
// comparator output conditioning, timer gate source and interrupt block
`timescale 1ns/1ps
`default_nettype none

module comparator_output_sync_irq (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  input  wire logic [cmp_irq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                     awprot,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [cmp_irq_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [cmp_irq_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                     arprot,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [cmp_irq_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  input  wire logic [cmp_irq_pkg::NUM_CMP-1:0] cmp_raw,
  output logic [cmp_irq_pkg::NUM_CMP-1:0]     hysteresis_enable,
  output logic [cmp_irq_pkg::NUM_CMP-1:0]     comparator_on,
  output logic [cmp_irq_pkg::NUM_CMP-1:0]     speed_power_select,
  input  wire logic                           timer_src_clk,
  input  wire logic                           timer_prescaled_clk,
  input  wire logic                           prescaler_enable,
  output logic [cmp_irq_pkg::NUM_CMP-1:0]     timer_gate_source,
  output logic                                timer_count_pulse,
  output logic                                irq
);
  import cmp_irq_pkg::*;

  // bus slave state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;
  logic [3:0]        next_wr_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              do_write;
  logic              wr_low;
  logic              wr_hit;
  logic              rd_hit;
  logic [DATA_W-1:0] rd_word;

  // software registers
  logic [NUM_CMP-1:0] output_polarity;
  logic [NUM_CMP-1:0] output_sync_enable;
  logic [NUM_CMP-1:0] rising_edge_irq_enable;
  logic [NUM_CMP-1:0] falling_edge_irq_enable;
  logic [NUM_CMP-1:0] comparator_irq_enable;
  logic               peripheral_irq_enable;
  logic               global_irq_enable;
  logic [NUM_CMP-1:0] next_on;
  logic [NUM_CMP-1:0] next_pol;
  logic [NUM_CMP-1:0] next_sp;
  logic [NUM_CMP-1:0] next_hys;
  logic [NUM_CMP-1:0] next_sync;
  logic [NUM_CMP-1:0] next_rise_en;
  logic [NUM_CMP-1:0] next_fall_en;
  logic [NUM_CMP-1:0] next_mask;
  logic               next_peripheral_irq_enable;
  logic               next_gie;
  logic [NUM_CMP-1:0] flag_clear;

  // timer clock edges and interrupt
  logic               sel_clk;
  logic               sel_prev;
  logic               latch_fall;
  logic               clk_rise;
  logic [NUM_CMP-1:0] gate;
  logic [NUM_CMP-1:0] comparator_irq_flag;
  logic               next_irq;

  // address decode of one comparator's control word
  function automatic logic is_ctrl(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] base,
                                   input int              idx);
    logic [ADDR_W-1:0] step;
    step    = CMP_STRIDE * ADDR_W'(idx);
    is_ctrl = (addr == (base + step));
  endfunction : is_ctrl

  // any mapped register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = (addr == OFF_FLAG) || (addr == OFF_MASK) ||
          (addr == OFF_INTCTL) || (addr == OFF_OUTSTAT);
    for (int i = 0; i < NUM_CMP; i++)
    begin
      hit = hit || is_ctrl(addr, OFF_CTRL0, i) || is_ctrl(addr, OFF_CTRL1, i);
    end
    is_mapped = hit;
  endfunction : is_mapped

  // read data for the address on the read channel
  always_comb
  begin
    rd_word = '0;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (is_ctrl(araddr, OFF_CTRL0, i))
      begin
        rd_word[CTRL0_ON_BIT]   = comparator_on[i];
        rd_word[CTRL0_POL_BIT]  = output_polarity[i];
        rd_word[CTRL0_SP_BIT]   = speed_power_select[i];
        rd_word[CTRL0_HYS_BIT]  = hysteresis_enable[i];
        rd_word[CTRL0_SYNC_BIT] = output_sync_enable[i];
      end
      if (is_ctrl(araddr, OFF_CTRL1, i))
      begin
        rd_word[CTRL1_RISE_BIT] = rising_edge_irq_enable[i];
        rd_word[CTRL1_FALL_BIT] = falling_edge_irq_enable[i];
      end
    end
    if (araddr == OFF_FLAG)
    begin
      rd_word[NUM_CMP-1:0] = comparator_irq_flag;
    end
    if (araddr == OFF_MASK)
    begin
      rd_word[NUM_CMP-1:0] = comparator_irq_enable;
    end
    if (araddr == OFF_INTCTL)
    begin
      rd_word[INTCTL_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable;
      rd_word[INTCTL_GIE_BIT]  = global_irq_enable;
    end
    if (araddr == OFF_OUTSTAT)
    begin
      rd_word[NUM_CMP-1:0] = gate;
    end
  end

  // bus handshakes, next values
  always_comb
  begin
    next_aw_held = aw_held | (awvalid & awready);
    next_w_held  = w_held | (wvalid & wready);
    next_wr_addr = (awvalid & awready) ? awaddr : wr_addr;
    next_wr_data = (wvalid & wready) ? wdata : wr_data;
    next_wr_strb = (wvalid & wready) ? wstrb : wr_strb;
    next_bvalid  = bvalid & ~bready;
    next_bresp   = bresp;
    do_write     = aw_held & w_held & ~bvalid;
    wr_hit       = is_mapped(wr_addr);
    wr_low       = do_write & wr_strb[0];
    if (do_write)
    begin
      next_aw_held = 1'h0;
      next_w_held  = 1'h0;
      next_bvalid  = 1'h1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
    rd_hit       = is_mapped(araddr);
    next_rvalid  = rvalid & ~rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid & arready)
    begin
      next_rvalid = 1'h1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_arready = ~next_rvalid;
  end

  // software register writes, next values
  always_comb
  begin
    next_on      = comparator_on;
    next_pol     = output_polarity;
    next_sp      = speed_power_select;
    next_hys     = hysteresis_enable;
    next_sync    = output_sync_enable;
    next_rise_en = rising_edge_irq_enable;
    next_fall_en = falling_edge_irq_enable;
    next_mask    = comparator_irq_enable;
    next_peripheral_irq_enable    = peripheral_irq_enable;
    next_gie     = global_irq_enable;
    flag_clear   = '0;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (wr_low && is_ctrl(wr_addr, OFF_CTRL0, i))
      begin
        next_on[i]   = wr_data[CTRL0_ON_BIT];
        next_pol[i]  = wr_data[CTRL0_POL_BIT];
        next_sp[i]   = wr_data[CTRL0_SP_BIT];
        next_hys[i]  = wr_data[CTRL0_HYS_BIT];
        next_sync[i] = wr_data[CTRL0_SYNC_BIT];
      end
      if (wr_low && is_ctrl(wr_addr, OFF_CTRL1, i))
      begin
        next_rise_en[i] = wr_data[CTRL1_RISE_BIT];
        next_fall_en[i] = wr_data[CTRL1_FALL_BIT];
      end
    end
    if (wr_low && wr_addr == OFF_FLAG)
    begin
      flag_clear = wr_data[NUM_CMP-1:0];
    end
    if (wr_low && wr_addr == OFF_MASK)
    begin
      next_mask = wr_data[NUM_CMP-1:0];
    end
    if (wr_low && wr_addr == OFF_INTCTL)
    begin
      next_peripheral_irq_enable = wr_data[INTCTL_PERIPHERAL_IRQ_ENABLE_BIT];
      next_gie  = wr_data[INTCTL_GIE_BIT];
    end
  end

  // timer clock edges and interrupt request, next values
  always_comb
  begin
    sel_clk    = prescaler_enable ? timer_prescaled_clk
                                  : timer_src_clk;
    latch_fall = sel_prev & ~sel_clk;
    clk_rise   = ~sel_prev & sel_clk;
    next_irq   = peripheral_irq_enable & global_irq_enable &
                 (|(comparator_irq_flag & comparator_irq_enable &
                    comparator_on));
  end

  // all block registers, frozen while ce is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held                 <= 1'h0;
      w_held                  <= 1'h0;
      wr_addr                 <= '0;
      wr_data                 <= '0;
      wr_strb                 <= '0;
      awready                 <= READY_RST;
      wready                  <= READY_RST;
      bvalid                  <= 1'h0;
      bresp                   <= RESP_OKAY;
      arready                 <= READY_RST;
      rvalid                  <= 1'h0;
      rdata                   <= '0;
      rresp                   <= RESP_OKAY;
      comparator_on           <= CMP_BITS_RST;
      output_polarity         <= CMP_BITS_RST;
      speed_power_select      <= CMP_BITS_RST;
      hysteresis_enable       <= CMP_BITS_RST;
      output_sync_enable      <= CMP_BITS_RST;
      rising_edge_irq_enable  <= CMP_BITS_RST;
      falling_edge_irq_enable <= CMP_BITS_RST;
      comparator_irq_enable   <= CMP_BITS_RST;
      peripheral_irq_enable   <= INTCTL_RST;
      global_irq_enable       <= INTCTL_RST;
      sel_prev                <= 1'h0;
      timer_count_pulse       <= 1'h0;
      irq                     <= 1'h0;
    end
    else if (ce)
    begin
      aw_held                 <= next_aw_held;
      w_held                  <= next_w_held;
      wr_addr                 <= next_wr_addr;
      wr_data                 <= next_wr_data;
      wr_strb                 <= next_wr_strb;
      awready                 <= next_awready;
      wready                  <= next_wready;
      bvalid                  <= next_bvalid;
      bresp                   <= next_bresp;
      arready                 <= next_arready;
      rvalid                  <= next_rvalid;
      rdata                   <= next_rdata;
      rresp                   <= next_rresp;
      comparator_on           <= next_on;
      output_polarity         <= next_pol;
      speed_power_select      <= next_sp;
      hysteresis_enable       <= next_hys;
      output_sync_enable      <= next_sync;
      rising_edge_irq_enable  <= next_rise_en;
      falling_edge_irq_enable <= next_fall_en;
      comparator_irq_enable   <= next_mask;
      peripheral_irq_enable   <= next_peripheral_irq_enable;
      global_irq_enable       <= next_gie;
      sel_prev                <= sel_clk;
      timer_count_pulse       <= clk_rise;
      irq                     <= next_irq;
    end
  end

  // one conditioning channel per comparator, gate goes to the timer
  for (genvar g = 0; g < NUM_CMP; g++)
  begin : gen_cmp
    cmp_channel u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .raw        (cmp_raw[g]),
      .on         (comparator_on[g]),
      .polarity   (output_polarity[g]),
      .sync_en    (output_sync_enable[g]),
      .latch_fall (latch_fall),
      .rise_en    (rising_edge_irq_enable[g]),
      .fall_en    (falling_edge_irq_enable[g]),
      .flag_clear (flag_clear[g]),
      .gate       (gate[g]),
      .flag       (comparator_irq_flag[g])
    );
  end

  // gate source is the channel's registered output
  assign timer_gate_source = gate;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hys_write: assert property
    (ce && wr_low && is_ctrl(wr_addr, OFF_CTRL0, 0)
     |=> hysteresis_enable[0] == $past(wr_data[CTRL0_HYS_BIT]))
    else $error("hysteresis enable did not follow the write");

  a_prescale_src: assert property
    (ce && prescaler_enable && sel_prev && !timer_prescaled_clk
     |-> latch_fall)
    else $error("prescaled clock fall did not latch");

  a_edges_apart: assert property
    (ce && latch_fall |=> !timer_count_pulse)
    else $error("count pulse coincides with latch update");

  a_irq_needs_gie: assert property
    (ce && !(global_irq_enable && peripheral_irq_enable) |=> !irq)
    else $error("interrupt raised without global enables");

  a_irq_raise: assert property
    (ce && next_irq |=> irq [*1] ##0 $past(comparator_irq_flag) != '0)
    else $error("enabled flag did not raise the interrupt");

endmodule : comparator_output_sync_irq

`default_nettype wire

/* bench/timer_model.sv */
// far-side timer model: timer clocks and gated tick counter
`timescale 1ns/1ps
`default_nettype none

module timer_model (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic pre_hold,
  input  wire logic gate,
  input  wire logic pulse,
  output var logic  src_clk,
  output var logic  pre_clk,
  output var int    ticks,
  output var int    clashes
);
  logic [2:0] div;
  logic       last_gate;

  // clocks start low and stand still until told to run
  initial
  begin
    src_clk = 1'b0;
    pre_clk = 1'b0;
    div = 3'h0;
    ticks = 0;
    clashes = 0;
    last_gate = 1'b0;
  end

  // source clock at an eighth of the aclk rate, prescaled one at half of that
  always @(posedge aclk)
  begin
    last_gate <= gate;
    if (run)
    begin
      div <= div + 3'h1;
      if (div[1:0] == 2'h3) src_clk <= ~src_clk;
      if (div == 3'h7 && !pre_hold) pre_clk <= ~pre_clk;
    end
    if (pulse && gate) ticks <= ticks + 1;
    if (pulse && gate != last_gate) clashes <= clashes + 1;
  end
endmodule : timer_model
`default_nettype wire

/* bench/comparator_output_sync_irq_bench.sv */
// self-checking bench for the comparator conditioning block
`timescale 1ns/1ps
`default_nettype none

module comparator_output_sync_irq_bench;
  import cmp_irq_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic              bready, arvalid, arready, rvalid, rready, irq;
  logic              prescaler_enable, pulse, src_clk, pre_clk;
  logic              run, pre_hold;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, cmp_raw, hys, on, sps, gate;
  int                bad_count, compares, cyc, ticks, clashes;
  logic [33:0]       exp_q[$];

  always #2.5 aclk = ~aclk;

  comparator_output_sync_irq i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cmp_raw(cmp_raw), .hysteresis_enable(hys), .comparator_on(on),
    .speed_power_select(sps), .timer_src_clk(src_clk),
    .timer_prescaled_clk(pre_clk), .prescaler_enable(prescaler_enable),
    .timer_gate_source(gate), .timer_count_pulse(pulse), .irq(irq)
  );

  timer_model i_timer (
    .aclk(aclk), .run(run), .pre_hold(pre_hold), .gate(gate[0]),
    .pulse(pulse), .src_clk(src_clk), .pre_clk(pre_clk),
    .ticks(ticks), .clashes(clashes)
  );

  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [33:0] exp,
                     input logic [33:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    // bready stays high, so a following call never lowers and raises it
    do @(posedge aclk); while (!bvalid);
    chk("bresp", {32'h0, r}, {32'h0, bresp});
  endtask : wr

  // read: note the expected word, the watcher compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back({r, d});
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    // rready stays high, so a following call never lowers and raises it
    do @(posedge aclk); while (!rvalid);
  endtask : rd

  // watcher: each read answer against the oldest note
  always @(posedge aclk)
    if (rvalid && rready) chk("read", exp_q.pop_front(), {rresp, rdata});

  // hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    void'($urandom(32'hb257));
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {cmp_raw, prescaler_enable, run, pre_hold} = 5'h0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL0, 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    wr(OFF_CTRL1 + CMP_STRIDE, 32'h3);
    wr(OFF_MASK, 32'h3);
    wr(OFF_INTCTL, 32'h3);
    // idle comparator: polarity flip, then switching it on
    wr(OFF_CTRL0 + CMP_STRIDE, 32'h10);
    cmp_raw[1] <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(OFF_FLAG, 32'h2);
    chk("irq", 34'h0, {33'h0, irq});
    wr(OFF_FLAG, 32'h2);
    wr(OFF_CTRL0 + CMP_STRIDE, 32'h94);
    repeat (8) @(posedge aclk);
    chk("irq", 34'h1, {33'h0, irq});
    wr(OFF_INTCTL, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq", 34'h0, {33'h0, irq});
    wr(OFF_INTCTL, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq", 34'h1, {33'h0, irq});
    wr(OFF_FLAG, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq", 34'h0, {33'h0, irq});
    // channel 0 with only the falling detector enabled
    wr(OFF_CTRL1, 32'h1);
    wr(OFF_CTRL0, 32'h82);
    chk("hys_on_sp", 34'h1e, {28'h0, hys, on, sps});
    rd(OFF_CTRL0, 32'h82);
    cmp_raw[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("gate", 34'h1, {33'h0, gate[0]});
    rd(OFF_FLAG, 32'h0);
    cmp_raw[0] <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(OFF_FLAG, 32'h1);
    // falling edge timed to reach the flag in the cycle of the clear
    cmp_raw[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp_raw[0] <= 1'b0;
    repeat (2) @(posedge aclk);
    wr(OFF_FLAG, 32'h1);
    rd(OFF_FLAG, 32'h1);
    wr(OFF_FLAG, 32'h1);
    rd(OFF_FLAG, 32'h0);
    // inverted polarity with random raw levels
    wr(OFF_CTRL0, 32'h92);
    repeat (6)
    begin
      cmp_raw[0] <= 1'($urandom);
      repeat (6) @(posedge aclk);
      chk("gate_inv", {33'h0, ~cmp_raw[0]}, {33'h0, gate[0]});
    end
    // settle the gate low, then enable sync before the timer runs
    cmp_raw[0] <= 1'b0;
    wr(OFF_CTRL0, 32'h82);
    repeat (6) @(posedge aclk);
    wr(OFF_CTRL0, 32'h83);
    repeat (6) @(posedge aclk);
    cmp_raw[0] <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("gate_hold", 34'h0, {33'h0, gate[0]});
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("gate_latch", 34'h1, {33'h0, gate[0]});
    chk("ticks", 34'h1, {33'h0, ticks != 0});
    chk("clashes", 34'h0, {2'h0, 32'(clashes)});
    rd(OFF_OUTSTAT, 32'h1);
    prescaler_enable <= 1'b1;
    pre_hold <= 1'b1;
    repeat (10) @(posedge aclk);
    cmp_raw[0] <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("gate_pre", 34'h1, {33'h0, gate[0]});
    pre_hold <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("gate_pre", 34'h0, {33'h0, gate[0]});
    end_of_test();
  end
endmodule : comparator_output_sync_irq_bench
`default_nettype wire
